/* File: ats_tx_status.sv */
// Transmit status flags, interrupt enables and DMA event of the audio port
`timescale 1ns/1ps
module ats_tx_status
  import ats_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [ats_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [ats_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [ats_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic TX_FRAME_SYNC_IN,
  input wire logic TX_SYNC_EARLY_IN,
  input wire logic TX_COPY_REQ_IN,
  input wire logic TX_BUF_WRITE_IN,
  input wire logic TX_SER_RUN_IN,
  input wire logic TX_FINAL_SLOT_IN,
  input wire logic [ats_pkg::SLOT_W-1:0] TX_SLOT_COUNT_IN,
  input wire logic TX_CLOCK_FAILURE_IN,
  input wire logic TX_DMA_ERROR_IN,
  output logic TX_INTERRUPT_OUT,
  output logic TX_INT_REQ_OUT,
  output logic TX_DMA_EVENT_OUT,
  output logic TX_BUF_FULL_OUT
);
  import ats_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    ats_flags_t enables;
    logic buf_full;
    logic ser_run_prev;
    logic dma_event;
    logic int_req;
    logic int_level;
  } ats_top_state_t;

  ats_top_state_t st_q;
  ats_top_state_t st_d;

  ats_flag_if flag_bus ();

  ats_sticky_bank u_bank (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .port(flag_bus.bank)
  );

  // Place the five event flags at their status bit positions
  function automatic logic [DATA_W-1:0] flags_to_status(input ats_flags_t f);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_UNDERFLOW] = f[FLG_UNDERFLOW];
    w[BIT_EARLY_SYNC] = f[FLG_EARLY_SYNC];
    w[BIT_FINAL_SLOT] = f[FLG_FINAL_SLOT];
    w[BIT_BUF_EMPTY] = f[FLG_BUF_EMPTY];
    w[BIT_FRAME_START] = f[FLG_FRAME_START];
    return w;
  endfunction

  // Pick the five event bits out of a status-layout word
  function automatic ats_flags_t status_to_flags(input logic [DATA_W-1:0] w);
    ats_flags_t f;
    f = '0;
    f[FLG_UNDERFLOW] = w[BIT_UNDERFLOW];
    f[FLG_EARLY_SYNC] = w[BIT_EARLY_SYNC];
    f[FLG_FINAL_SLOT] = w[BIT_FINAL_SLOT];
    f[FLG_BUF_EMPTY] = w[BIT_BUF_EMPTY];
    f[FLG_FRAME_START] = w[BIT_FRAME_START];
    return f;
  endfunction

  // Enable word places the event bits as status does, except frame start at bit 7
  function automatic logic [DATA_W-1:0] enables_to_word(input ats_flags_t e);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_UNDERFLOW] = e[FLG_UNDERFLOW];
    w[BIT_EARLY_SYNC] = e[FLG_EARLY_SYNC];
    w[BIT_FINAL_SLOT] = e[FLG_FINAL_SLOT];
    w[BIT_BUF_EMPTY] = e[FLG_BUF_EMPTY];
    w[BIT_EN_FRAME_START] = e[FLG_FRAME_START];
    return w;
  endfunction

  function automatic ats_flags_t word_to_enables(input logic [DATA_W-1:0] w);
    ats_flags_t e;
    e = '0;
    e[FLG_UNDERFLOW] = w[BIT_UNDERFLOW];
    e[FLG_EARLY_SYNC] = w[BIT_EARLY_SYNC];
    e[FLG_FINAL_SLOT] = w[BIT_FINAL_SLOT];
    e[FLG_BUF_EMPTY] = w[BIT_BUF_EMPTY];
    e[FLG_FRAME_START] = w[BIT_EN_FRAME_START];
    return e;
  endfunction

  logic ser_release;
  logic buf_copy;
  logic buf_empty_set;
  logic underflow_set;
  logic error_summary;
  logic slot_parity;
  logic wr_status;
  logic wr_clear;
  logic wr_enables;
  ats_flags_t sw_clear;
  ats_flags_t hw_set;
  ats_flags_t buf_write_clear;
  logic [DATA_W-1:0] status_word;

  // Serializers leave reset on the rising edge of the run level
  assign ser_release = TX_SER_RUN_IN & ~st_q.ser_run_prev;

  assign buf_copy = TX_COPY_REQ_IN;

  // A write landing with the copy counts as fresh data
  assign underflow_set = buf_copy & ~st_q.buf_full & ~TX_BUF_WRITE_IN; // RL13

  assign buf_empty_set = buf_copy | ser_release; // RL6 RL8

  always_comb
  begin
    hw_set = '0;
    hw_set[FLG_FRAME_START] = TX_FRAME_SYNC_IN; // RL3
    hw_set[FLG_BUF_EMPTY] = buf_empty_set; // RL6
    hw_set[FLG_FINAL_SLOT] = buf_empty_set & TX_FINAL_SLOT_IN; // RL10
    hw_set[FLG_EARLY_SYNC] = TX_SYNC_EARLY_IN; // RL12
    hw_set[FLG_UNDERFLOW] = underflow_set; // RL13
  end

  assign wr_status = REG_WR_IN & (REG_ADDR_IN == OFS_TRANSMIT_STATUS);
  assign wr_clear = REG_WR_IN & (REG_ADDR_IN == OFS_TX_FLAG_CLEAR);
  assign wr_enables = REG_WR_IN & (REG_ADDR_IN == OFS_TX_INTERRUPT_ENABLES);

  // Only ones clear; reserved and read-only positions are not decoded
  assign sw_clear = (wr_status | wr_clear) ?
                    status_to_flags(REG_WDATA_IN) : '0; // RL4 RL14

  // Filling the holding buffer withdraws the buffer empty flag unless a copy or release sets it in the same cycle
  always_comb
  begin
    buf_write_clear = '0;
    buf_write_clear[FLG_BUF_EMPTY] = TX_BUF_WRITE_IN; // RL7
  end

  assign flag_bus.set = hw_set;
  assign flag_bus.clr = sw_clear | buf_write_clear;

  assign error_summary = flag_bus.flags[FLG_UNDERFLOW]
                       | flag_bus.flags[FLG_EARLY_SYNC]
                       | TX_CLOCK_FAILURE_IN
                       | TX_DMA_ERROR_IN; // RL2 RL17

  assign slot_parity = TX_SLOT_COUNT_IN[0]; // RL11

  always_comb
  begin
    status_word = flags_to_status(flag_bus.flags);
    status_word[BIT_SLOT_PARITY] = slot_parity; // RL11
    status_word[BIT_ERROR_SUMMARY] = error_summary; // RL2
  end

  always_comb
  begin
    st_d = st_q;
    st_d.ser_run_prev = TX_SER_RUN_IN;

    // Holding buffer occupancy; a write beats a copy in the same cycle
    if (TX_BUF_WRITE_IN)
      st_d.buf_full = 1'b1;
    else if (buf_copy)
      st_d.buf_full = 1'b0;

    // Every setting of the empty flag asks the DMA for data
    st_d.dma_event = buf_empty_set; // RL9

    if (wr_enables)
      st_d.enables = word_to_enables(REG_WDATA_IN); // RL16

    // One-cycle request on each enabled set, even over a standing flag
    st_d.int_req = |(flag_bus.fresh & st_q.enables); // RL1

    // Level trails the flags by one cycle, so a clear drops it a cycle late
    st_d.int_level = |(flag_bus.flags & st_q.enables); // RL5

    st_d.rdata = '0;
    if (REG_RD_IN)
    begin
      unique case (REG_ADDR_IN)
        OFS_TRANSMIT_STATUS:
          st_d.rdata = status_word; // RL14
        OFS_TX_INTERRUPT_ENABLES:
          st_d.rdata = enables_to_word(st_q.enables);
        default:
          st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      st_q <= '{rdata: RST_RDATA,
                enables: RST_ENABLES,
                buf_full: RST_BUF_FULL,
                ser_run_prev: RST_RELEASE,
                dma_event: 1'b0,
                int_req: 1'b0,
                int_level: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA_OUT = st_q.rdata;
  assign TX_INTERRUPT_OUT = st_q.int_level; // RL5
  assign TX_INT_REQ_OUT = st_q.int_req; // RL1
  assign TX_DMA_EVENT_OUT = st_q.dma_event; // RL9
  assign TX_BUF_FULL_OUT = st_q.buf_full;
endmodule

/* File: ats_pkg.sv */
// Constants and types shared by the transmit status flag block
// Operation
// RL1 - A hardware set in the same cycle as a software clear wins; interrupt reasserts.
// RL2 - Bit 8 reads the OR of underflow, early sync, clock failure, DMA error.
// RL3 - Bit 6 sets on a new frame sync and reads 0 otherwise.
// RL4 - Event flags clear only by writing 1; writing 0 leaves them alone.
// RL5 - Interrupt is high while any flag is set with its enable set.
// RL6 - Bit 5 sets when the holding buffer is copied into the shift register.
// RL7 - Bit 5 reads 0 once the holding buffer has been written. A write in the cycle of a copy or serializer release leaves bit 5 set.
// RL8 - Bit 5 also sets when the serializers leave reset.
// RL9 - Every setting of bit 5 issues a DMA event, whatever the enables.
// RL10 - Bit 4 sets with bit 5 when the current slot is the final one.
// RL11 - Read-only bit 3 is the slot counter LSB; 1 means even slot.
// RL12 - Bit 1 sets when a frame sync comes earlier than expected.
// RL13 - Bit 0 sets on a copy request when the buffer got no new data.
// RL14 - Reserved bits 31-9, 7 and 2 read 0; writes to them do nothing.
// RL15 - Software writes 0 into every reserved bit position.
// RL16 - Enable bits: frame start 7, buffer empty 5, final slot 4, sync 1, underflow 0.
// RL17 - Clock failure and DMA error arrive as level inputs from outside.
package ats_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SLOT_W = 9;
  localparam int NUM_FLAGS = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TX_INTERRUPT_ENABLES = 8'hbc;
  localparam logic [ADDR_W-1:0] OFS_TRANSMIT_STATUS = 8'hc0;
  localparam logic [ADDR_W-1:0] OFS_TX_FLAG_CLEAR = 8'hd0;

  // Bit positions in the status and enable words
  localparam int BIT_UNDERFLOW = 0;
  localparam int BIT_EARLY_SYNC = 1;
  localparam int BIT_SLOT_PARITY = 3;
  localparam int BIT_FINAL_SLOT = 4;
  localparam int BIT_BUF_EMPTY = 5;
  localparam int BIT_FRAME_START = 6;
  localparam int BIT_EN_FRAME_START = 7;
  localparam int BIT_ERROR_SUMMARY = 8;

  // Index of each event flag inside the sticky bank
  localparam int FLG_UNDERFLOW = 0;
  localparam int FLG_EARLY_SYNC = 1;
  localparam int FLG_FINAL_SLOT = 2;
  localparam int FLG_BUF_EMPTY = 3;
  localparam int FLG_FRAME_START = 4;

  // Reset values
  localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 5'h00;
  localparam logic [NUM_FLAGS-1:0] RST_ENABLES = 5'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;
  localparam logic RST_BUF_FULL = 1'b0;
  localparam logic RST_RELEASE = 1'b0;

  typedef logic [NUM_FLAGS-1:0] ats_flags_t;
endpackage

/* File: ats_flag_if.sv */
// Set, clear and state lines of the sticky event flag bank
`timescale 1ns/1ps
interface ats_flag_if;
  import ats_pkg::*;
  ats_flags_t set;
  ats_flags_t clr;
  ats_flags_t flags;
  ats_flags_t fresh;
  modport ctrl (output set, output clr, input flags, input fresh);
  modport bank (input set, input clr, output flags, output fresh);
endinterface

/* File: ats_sticky_bank.sv */
// Bank of sticky event flags where a set beats a clear
`timescale 1ns/1ps
module ats_sticky_bank
  import ats_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  ats_flag_if.bank port
);
  typedef struct packed {
    ats_flags_t flags;
  } ats_bank_state_t;

  ats_bank_state_t st_q;
  ats_bank_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < NUM_FLAGS; i++)
    begin
      // Clear first, set last, so a set in the clear cycle survives
      if (port.clr[i])
        st_d.flags[i] = 1'b0; // RL4
      if (port.set[i])
        st_d.flags[i] = 1'b1; // RL1
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_q <= '{flags: RST_FLAGS};
    else
      st_q <= st_d;
  end

  assign port.flags = st_q.flags;
  // A set reaches the interrupt logic again even if the flag already stood
  assign port.fresh = port.set;
endmodule

/* File: ats_tx_status_props.sv */
// Port-level assertions for the transmit status flag block
`timescale 1ns/1ps
module ats_tx_status_props
  import ats_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic [ats_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [ats_pkg::DATA_W-1:0] REG_RDATA_OUT,
  input wire logic TX_FRAME_SYNC_IN,
  input wire logic TX_SYNC_EARLY_IN,
  input wire logic TX_COPY_REQ_IN,
  input wire logic TX_BUF_WRITE_IN,
  input wire logic TX_SER_RUN_IN,
  input wire logic TX_FINAL_SLOT_IN,
  input wire logic [ats_pkg::SLOT_W-1:0] TX_SLOT_COUNT_IN,
  input wire logic TX_CLOCK_FAILURE_IN,
  input wire logic TX_DMA_ERROR_IN,
  input wire logic TX_INTERRUPT_OUT,
  input wire logic TX_INT_REQ_OUT,
  input wire logic TX_DMA_EVENT_OUT,
  input wire logic TX_BUF_FULL_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_rd;
    REG_RD_IN && REG_ADDR_IN == OFS_TRANSMIT_STATUS;
  endsequence
  property p_rsvd;
    REG_RDATA_OUT[31:9] == '0 && !REG_RDATA_OUT[7] && !REG_RDATA_OUT[2];
  endproperty
  property p_slot;
    s_rd |=> REG_RDATA_OUT[3] == $past(TX_SLOT_COUNT_IN[0]);
  endproperty
  property p_err;
    s_rd |=> REG_RDATA_OUT[8] == (REG_RDATA_OUT[0] || REG_RDATA_OUT[1]
      || $past(TX_CLOCK_FAILURE_IN) || $past(TX_DMA_ERROR_IN));
  endproperty
  property p_sync;
    TX_FRAME_SYNC_IN ##1 s_rd |=> REG_RDATA_OUT[6];
  endproperty
  property p_early;
    TX_SYNC_EARLY_IN ##1 s_rd |=> REG_RDATA_OUT[1];
  endproperty
  property p_last;
    TX_COPY_REQ_IN && TX_FINAL_SLOT_IN ##1 s_rd |=> REG_RDATA_OUT[5:4] == 2'h3;
  endproperty
  // Write in the copy cycle counts as serviced, so it must not flag
  property p_under;
    TX_COPY_REQ_IN && !TX_BUF_WRITE_IN && !TX_BUF_FULL_OUT ##1 s_rd
      |=> REG_RDATA_OUT[0];
  endproperty
  property p_dma;
    TX_COPY_REQ_IN || $rose(TX_SER_RUN_IN) |=> TX_DMA_EVENT_OUT;
  endproperty
  property p_int;
    TX_INT_REQ_OUT |=> TX_INTERRUPT_OUT;
  endproperty
  property p_full;
    TX_BUF_WRITE_IN |=> TX_BUF_FULL_OUT;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_slot: assert property (p_slot) else $error("slot parity");
  a_err: assert property (p_err) else $error("error summary");
  a_sync: assert property (p_sync) else $error("frame start");
  a_early: assert property (p_early) else $error("early sync");
  a_last: assert property (p_last) else $error("final slot");
  a_under: assert property (p_under) else $error("underflow");
  a_dma: assert property (p_dma) else $error("dma event");
  a_int: assert property (p_int) else $error("interrupt level");
  a_full: assert property (p_full) else $error("buffer full");
endmodule
bind ats_tx_status ats_tx_status_props u_props (.CLK_IN(CLK_IN),
  .SYS_RST_IN(SYS_RST_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .TX_FRAME_SYNC_IN(TX_FRAME_SYNC_IN),
  .TX_SYNC_EARLY_IN(TX_SYNC_EARLY_IN), .TX_COPY_REQ_IN(TX_COPY_REQ_IN),
  .TX_BUF_WRITE_IN(TX_BUF_WRITE_IN), .TX_SER_RUN_IN(TX_SER_RUN_IN),
  .TX_FINAL_SLOT_IN(TX_FINAL_SLOT_IN), .TX_SLOT_COUNT_IN(TX_SLOT_COUNT_IN),
  .TX_CLOCK_FAILURE_IN(TX_CLOCK_FAILURE_IN),
  .TX_DMA_ERROR_IN(TX_DMA_ERROR_IN), .TX_INTERRUPT_OUT(TX_INTERRUPT_OUT),
  .TX_INT_REQ_OUT(TX_INT_REQ_OUT), .TX_DMA_EVENT_OUT(TX_DMA_EVENT_OUT),
  .TX_BUF_FULL_OUT(TX_BUF_FULL_OUT));

/* File: ats_tx_status_bench.sv */
// Self-checking bench for the transmit status flag block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module ats_tx_status_bench;
  import ats_pkg::*;
  localparam logic [ADDR_W-1:0] st = OFS_TRANSMIT_STATUS;
  localparam logic [ADDR_W-1:0] en = OFS_TX_INTERRUPT_ENABLES;
  localparam logic [ADDR_W-1:0] cl = OFS_TX_FLAG_CLEAR;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rd_d = 0, run = 0, fin = 0;
  logic ckf = 0, dme = 0, irq, ireq, dma, full;
  logic [3:0] ev = '0;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wd = '0, rdat, r;
  logic [SLOT_W-1:0] slot = '0;
  logic [DATA_W+1:0] exq[$], ex;
  int fail_count = 0, num_checks = 0, cyc = 0, ndma = 0, nreq = 0;
  integer seed = 32'h7cce7dd3;
  ats_tx_status DUT (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(adr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdat),
    .TX_FRAME_SYNC_IN(ev[3]), .TX_SYNC_EARLY_IN(ev[2]),
    .TX_COPY_REQ_IN(ev[1]), .TX_BUF_WRITE_IN(ev[0]), .TX_SER_RUN_IN(run),
    .TX_FINAL_SLOT_IN(fin), .TX_SLOT_COUNT_IN(slot),
    .TX_CLOCK_FAILURE_IN(ckf), .TX_DMA_ERROR_IN(dme),
    .TX_INTERRUPT_OUT(irq), .TX_INT_REQ_OUT(ireq), .TX_DMA_EVENT_OUT(dma),
    .TX_BUF_FULL_OUT(full));
  always #20 clk = ~clk;
  task automatic complete_run;
    $display("Checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Every call drives all strobes once, so back-to-back calls never glitch
  task automatic op(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [3:0] e);
    wr <= w; rd <= 0; adr <= a; wd <= d; ev <= e;
    @(posedge clk);
  endtask
  // Note holds interrupt, buffer full and read word as seen after the read
  task automatic rs(input logic [ADDR_W-1:0] a, input logic [DATA_W+1:0] e);
    wr <= 0; rd <= 1; adr <= a; ev <= '0; exq.push_back(e);
    @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    rd_d <= rd;
    cyc++;
    if (dma === 1'b1) ndma++;
    if (ireq === 1'b1) nreq++;
    if (rd_d)
    begin
      ex = exq.pop_front();
      `CHK({irq, full, rdat}, ex)
    end
    if (cyc == 2000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    rs(st, 34'h0);
    rs(en, 34'h0);
    rs(8'h44, 34'h0);
    r = $random(seed);
    op(1, en, r, 4'h0);
    rs(en, {2'h0, r & 32'hb3});
    op(1, en, 32'hb3, 4'h0);
    run <= 1;
    op(0, '0, '0, 4'h0);
    rs(st, {2'h2, 32'h20});
    op(1, st, '0, 4'h0);
    rs(st, {2'h2, 32'h20});
    op(0, '0, '0, 4'h1);
    rs(st, {2'h1, 32'h0});
    fin <= 1;
    op(0, '0, '0, 4'h2);
    fin <= 0;
    rs(st, {2'h2, 32'h30});
    op(1, cl, 32'h30, 4'h0);
    rs(cl, 34'h0);
    rs(st, 34'h0);
    op(0, '0, '0, 4'h2);
    rs(st, {2'h2, 32'h121});
    op(1, st, 32'h21, 4'h2);
    rs(st, {2'h2, 32'h121});
    op(1, st, 32'h73, 4'h0);
    rs(st, 34'h0);
    op(0, '0, '0, 4'hc);
    rs(st, {2'h2, 32'h142});
    op(1, cl, 32'h42, 4'h0);
    slot <= 9'h0f5;
    ckf <= 1;
    rs(st, {2'h0, 32'h108});
    ckf <= 0;
    dme <= 1;
    r = $random(seed);
    slot <= r[SLOT_W-1:0];
    rs(st, {2'h0, 24'h1, 4'h0, r[0], 3'h0});
    dme <= 0;
    op(1, en, '0, 4'h0);
    op(0, '0, '0, 4'h8);
    rs(st, {2'h0, 32'h40});
    op(1, en, 32'h80, 4'h0);
    rs(st, {2'h2, 32'h40});
    op(1, cl, 32'h40, 4'h0);
    rs(st, 34'h0);
    // Reset mid-run with the serializers still running re-arms bit 5
    rst <= 1;
    slot <= '0;
    op(0, '0, '0, 4'h0);
    op(0, '0, '0, 4'h0);
    rst <= 0;
    rs(st, 34'h0);
    rs(st, {2'h0, 32'h20});
    op(0, '0, '0, 4'h0);
    op(0, '0, '0, 4'h0);
    `CHK(ndma, 5)
    `CHK(nreq, 5)
    complete_run;
  end
endmodule
